// >>> core/iac_calib_seq.sv
// Autocalibration sequencer with volatile correction store.
// Assumes an external analog calibration engine reports done and result.
module iac_calib_seq #(
   parameter longint MAX_CYC = iac_pkg::CALIB_MAX_CYC
)
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        start,
   input  wire logic        eng_done,
   input  wire logic        eng_ok,
   input  wire logic [31:0] eng_corr,
   output logic             busy,
   output logic             finish,
   output logic             ok,
   output logic [31:0]      corr [iac_pkg::CAL_WORDS]
);
   typedef struct packed
   {
      iac_pkg::iac_cal_state_t state;
      logic [31:0]             cnt;
      logic [1:0]              widx;
      logic                    ok;
      logic [iac_pkg::CAL_WORDS*32-1:0] corr;
   } iac_cal_t;
   iac_cal_t st;
   iac_cal_t next_st;
   // ======================================================================
   always_comb
   begin
      next_st = st;
      case (st.state)
         iac_pkg::IAC_CAL_IDLE:
         begin
            next_st.cnt  = '0;
            next_st.widx = '0;
            if (start)                            // [RULE2]
               next_st.state = iac_pkg::IAC_CAL_RUN;
         end
         iac_pkg::IAC_CAL_RUN:
         begin
            next_st.cnt = st.cnt + 32'h0000_0001;
            if (eng_done)
            begin
               // Corrections live only in flops; lost with power
               next_st.corr[st.widx*32 +: 32] = eng_corr;   // [RULE6]
               next_st.widx  = st.widx + 2'h1;
               next_st.ok    = eng_ok;                      // [RULE4]
               next_st.state = iac_pkg::IAC_CAL_DONE;
            end
            else if (st.cnt >= 32'(MAX_CYC - 1))
            begin
               // Engine silent past the limit counts as failure
               next_st.ok    = 1'b0;                        // [RULE4]
               next_st.state = iac_pkg::IAC_CAL_DONE;       // [RULE2]
            end
         end
         iac_pkg::IAC_CAL_DONE:
            next_st.state = iac_pkg::IAC_CAL_IDLE;
         default:
            next_st.state = iac_pkg::IAC_CAL_IDLE;
      endcase
   end
   assign busy   = (st.state == iac_pkg::IAC_CAL_RUN);
   assign finish = (st.state == iac_pkg::IAC_CAL_DONE);
   assign ok     = st.ok;
   genvar gi;
   generate
      for (gi = 0; gi < iac_pkg::CAL_WORDS; gi++)
      begin : g_corr
         assign corr[gi] = st.corr[gi*32 +: 32];
      end
   endgenerate
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st       <= '0;
         st.state <= iac_pkg::IAC_CAL_IDLE;
         st.ok    <= 1'b1;                        // [RULE5]
      end
      else if (clk_en)
         st <= next_st;
   end
endmodule

// >>> core/iac_edge_det.sv
// Rising edge detector of one raw event condition.
// Assumes synchronous inputs and one clock.
module iac_edge_det
(
   input  wire logic sys_clk,
   input  wire logic nrst,
   input  wire logic clk_en,
   input  wire logic cond,
   output logic      rise
);
   typedef struct packed
   {
      logic prev;
   } iac_edge_t;
   iac_edge_t st;
   iac_edge_t next_st;
   // ======================================================================
   // One raw condition per instance; selection happens after the edge
   always_comb
   begin
      next_st      = st;
      next_st.prev = cond;
   end
   assign rise = cond & ~st.prev;                 // [RULE14]
   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         st <= '0;
      else if (clk_en)
         st <= next_st;
   end
endmodule

// >>> core/iac_top.sv
// Local interrupt request and autocalibration control, APB slave.
// Assumes synchronous event inputs and a host bridge that forwards
// the local request only when its own enables are set.
module iac_top #(
   parameter longint CALIB_MAX_CYC = iac_pkg::CALIB_MAX_CYC
)
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        init_done,
   input  wire logic        sample_start,
   input  wire logic        data_ready,
   input  wire logic        burst_busy,
   input  wire logic        buf_threshold,
   input  wire logic        buf_over_under,
   input  wire logic        cal_eng_done,
   input  wire logic        cal_eng_ok,
   input  wire logic [31:0] cal_eng_corr,
   input  wire logic [15:0] analog_ctrl_in,
   output logic [15:0]      analog_ctrl,
   output logic             calib_running,
   output logic [31:0]      cal_corr0,
   output logic             local_irq
);
   typedef struct packed
   {
      logic [2:0]  sel0;
      logic [2:0]  sel1;
      logic        pend0;
      logic        pend1;
      logic        calib_start;
      logic [15:0] actrl;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        irq;
      logic        running;
      logic [31:0] corr0;
   } iac_top_t;
   iac_top_t st;
   iac_top_t next_st;

   logic        cal_busy;
   logic        cal_finish;
   logic        cal_ok;
   logic [31:0] cal_corr [iac_pkg::CAL_WORDS];
   logic [8:0]  conds;
   logic [8:0]  rises;
   logic        rise0;
   logic        rise1;
   logic        wr_ic;
   logic        wr_bcr;
   logic        rd;
   logic        hit;
   logic        start_pulse;
   logic        cal_done_ev;
   logic [31:0] ic_word;
   logic [31:0] bcr_word;

   // ======================================================================
   // Calibration sequencer
   iac_calib_seq #(
      .MAX_CYC (CALIB_MAX_CYC)
   ) u_cal (
      .sys_clk  (sys_clk),
      .nrst     (nrst),
      .clk_en   (clk_en),
      .start    (start_pulse),
      .eng_done (cal_eng_done),
      .eng_ok   (cal_eng_ok),
      .eng_corr (cal_eng_corr),
      .busy     (cal_busy),
      .finish   (cal_finish),
      .ok       (cal_ok),
      .corr     (cal_corr)
   );

   // ======================================================================
   // Edge detection per raw condition, then selection of the edge.
   // Selecting after the edge keeps a selector write from faking one.
   assign conds = {buf_over_under, ~buf_threshold, buf_threshold,
                   ~burst_busy, burst_busy, data_ready, sample_start,
                   cal_done_ev, init_done};

   genvar gi;
   generate
      for (gi = 0; gi < 9; gi++)
      begin : g_edge
         iac_edge_det u_edge (
            .sys_clk (sys_clk),
            .nrst    (nrst),
            .clk_en  (clk_en),
            .cond    (conds[gi]),
            .rise    (rises[gi])
         );
      end
   endgenerate

   always_comb
   begin
      case (st.sel0)                                           // [RULE21]
         iac_pkg::EV0_INIT_DONE:   rise0 = rises[0];           // [RULE13]
         iac_pkg::EV0_CALIB_DONE:  rise0 = rises[1];           // [RULE20]
         iac_pkg::EV0_SAMPLE_GO:   rise0 = rises[2];
         iac_pkg::EV0_DATA_READY:  rise0 = rises[3];
         iac_pkg::EV0_BURST_START: rise0 = rises[4];           // [RULE19]
         iac_pkg::EV0_BURST_END:   rise0 = rises[5];           // [RULE19]
         default:                  rise0 = 1'b0;               // [RULE15]
      endcase
      case (st.sel1)                                           // [RULE21]
         iac_pkg::EV1_THR_RISE:    rise1 = rises[6];
         iac_pkg::EV1_THR_FALL:    rise1 = rises[7];
         iac_pkg::EV1_OVER_UNDER:  rise1 = rises[8];
         default:                  rise1 = 1'b0;               // [RULE16]
      endcase
   end

   // ======================================================================
   // Bus decode; one wait state, writes land on the completing edge
   assign hit    = (paddr == iac_pkg::ADDR_INTERRUPT_CONTROL) ||
                   (paddr == iac_pkg::ADDR_BOARD_CONTROL_REG);
   assign wr_ic  = psel & penable & st.pready & pwrite &
                   (paddr == iac_pkg::ADDR_INTERRUPT_CONTROL);
   assign wr_bcr = psel & penable & st.pready & pwrite &
                   (paddr == iac_pkg::ADDR_BOARD_CONTROL_REG);
   assign rd     = psel & penable & ~st.pready & ~pwrite;
   assign start_pulse = wr_bcr & pwdata[iac_pkg::BCR_CALIB_START_BIT]
                        & ~st.calib_start;                     // [RULE2]
   // Falling start bit marks completion
   assign cal_done_ev = ~st.calib_start;                       // [RULE20]

   always_comb
   begin
      ic_word = 32'h0000_0000;
      ic_word[iac_pkg::ICR_SEL0_LSB +: 3] = st.sel0;
      ic_word[iac_pkg::ICR_PEND0_BIT]     = st.pend0;
      ic_word[iac_pkg::ICR_SEL1_LSB +: 3] = st.sel1;
      ic_word[iac_pkg::ICR_PEND1_BIT]     = st.pend1;
      bcr_word = 32'h0000_0000;
      bcr_word[iac_pkg::BCR_CALIB_START_BIT] = st.calib_start;
      bcr_word[iac_pkg::BCR_CALIB_OK_BIT]    = cal_ok;         // [RULE4]
   end

   // ======================================================================
   // Register and request state
   always_comb
   begin
      next_st         = st;
      next_st.pready  = psel & penable & ~st.pready;
      next_st.pslverr = psel & penable & ~st.pready & ~hit;
      if (rd)
         next_st.prdata = (paddr == iac_pkg::ADDR_INTERRUPT_CONTROL)
                          ? ic_word
                          : ((paddr == iac_pkg::ADDR_BOARD_CONTROL_REG)
                             ? bcr_word : 32'h0000_0000);
      if (wr_ic)
      begin
         next_st.sel0 = pwdata[iac_pkg::ICR_SEL0_LSB +: 3];
         next_st.sel1 = pwdata[iac_pkg::ICR_SEL1_LSB +: 3];
         // Writing zero clears; writing one leaves flag as is
         if (!pwdata[iac_pkg::ICR_PEND0_BIT])
            next_st.pend0 = 1'b0;                              // [RULE17]
         if (!pwdata[iac_pkg::ICR_PEND1_BIT])
            next_st.pend1 = 1'b0;                              // [RULE18]
      end
      // Set after clear: an event in the clearing cycle survives
      if (rise0)
         next_st.pend0 = 1'b1;                                 // [RULE12]
      if (rise1)
         next_st.pend1 = 1'b1;                                 // [RULE12]
      if (start_pulse)
         next_st.calib_start = 1'b1;                           // [RULE1]
      else if (cal_finish)
         next_st.calib_start = 1'b0;                           // [RULE1]
      // Control outputs frozen and analog inputs ignored while running
      if (!cal_busy && !start_pulse)
         next_st.actrl = analog_ctrl_in;                       // [RULE3]
      next_st.running = cal_busy | start_pulse;                // [RULE3]
      next_st.corr0   = cal_corr[0];                           // [RULE6]
      next_st.irq     = next_st.pend0 | next_st.pend1;         // [RULE11]
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         st       <= '0;
         st.pend0 <= iac_pkg::RST_INTERRUPT_CONTROL[iac_pkg::ICR_PEND0_BIT];
         st.irq   <= iac_pkg::RST_INTERRUPT_CONTROL[iac_pkg::ICR_PEND0_BIT];
      end
      else if (clk_en)
         st <= next_st;
   end

   // Host forwarding is gated in the bridge by its own enables
   assign local_irq     = st.irq;                              // [RULE9]
   assign prdata        = st.prdata;
   assign pready        = st.pready;
   assign pslverr       = st.pslverr;
   assign analog_ctrl   = st.actrl;
   assign calib_running = st.running;
   assign cal_corr0     = st.corr0;
endmodule

// >>> pkg/iac_pkg.sv
// Constants and types for the interrupt and calibration control block.
// Assumes one 20 MHz clock domain and an APB register bus.
// ==========================================================================
// What this block and the host software do
// RULE1: Start bit set by software, self-clears
// RULE2: Start accepted only while idle, run within four seconds
// RULE3: Settings frozen, analog inputs ignored during run
// RULE4: Failed run clears calib ok bit
// RULE5: Calib ok starts high after reset
// RULE6: Correction values kept in volatile flops
// RULE7: Software recalibrates after reset or range change
// RULE8: Software waits for done event or timeout
// RULE9: Host interrupt needs request and bridge enable
// RULE10: Host sets both bridge enable bits
// RULE11: Two groups ORed onto one request line
// RULE12: Selected event sets sticky group flag
// RULE13: Init done raises group zero request
// RULE14: Only false-to-true transitions raise requests
// RULE15: Group zero selector codes in bits 2:0
// RULE16: Group one selector codes in bits 6:4
// RULE17: Group zero flag bit 3, resets high
// RULE18: Group one flag bit 7, resets low
// RULE19: Burst busy edges give burst events
// RULE20: Calib done is start bit falling
// RULE21: Selector change alone raises nothing
package iac_pkg;
   // ======================================================================
   // Register map
   localparam logic [11:0] ADDR_INTERRUPT_CONTROL = 12'h004;
   localparam logic [11:0] ADDR_BOARD_CONTROL_REG = 12'h000;
   localparam logic [31:0] RST_INTERRUPT_CONTROL  = 32'h0000_0008;
   // Board control fields
   localparam int BCR_CALIB_START_BIT = 0;
   localparam int BCR_CALIB_OK_BIT    = 1;
   // Interrupt control fields
   localparam int ICR_SEL0_LSB  = 0;
   localparam int ICR_PEND0_BIT = 3;
   localparam int ICR_SEL1_LSB  = 4;
   localparam int ICR_PEND1_BIT = 7;
   // ======================================================================
   // Event codes
   localparam logic [2:0] EV0_INIT_DONE   = 3'h0;
   localparam logic [2:0] EV0_CALIB_DONE  = 3'h1;
   localparam logic [2:0] EV0_SAMPLE_GO   = 3'h2;
   localparam logic [2:0] EV0_DATA_READY  = 3'h3;
   localparam logic [2:0] EV0_BURST_START = 3'h4;
   localparam logic [2:0] EV0_BURST_END   = 3'h5;
   localparam logic [2:0] EV1_NONE        = 3'h0;
   localparam logic [2:0] EV1_THR_RISE    = 3'h1;
   localparam logic [2:0] EV1_THR_FALL    = 3'h2;
   localparam logic [2:0] EV1_OVER_UNDER  = 3'h3;
   // ======================================================================
   // Timing
   localparam longint CLK_HZ          = 20_000_000;
   localparam longint CALIB_MAX_MS    = 4000;
   localparam longint CALIB_MAX_CYC   = CLK_HZ / 1000 * CALIB_MAX_MS;
   localparam int     CAL_WORDS       = 4;
   // ======================================================================
   typedef enum logic [2:0]
   {
      IAC_CAL_IDLE = 3'b001,
      IAC_CAL_RUN  = 3'b010,
      IAC_CAL_DONE = 3'b100
   } iac_cal_state_t;
endpackage

// >>> test/iac_bridge_model.sv
// Host bridge model: forwards the local request to the host line.
// Assumes host software sets the two enables.
module iac_bridge_model
(
   input  wire logic local_irq,
   input  wire logic host_irq_en,
   input  wire logic local_in_en,
   output logic      host_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================
   // Both enables needed, so a half-set bridge stays silent
   assign host_irq = local_irq & host_irq_en & local_in_en;
endmodule

// >>> test/iac_monitor.sv
// Concurrent checks on the ports of the interrupt and calibration block.
// Assumes one clock domain; attached to iac_top by the bind below.
module iac_monitor #(
   parameter longint CALIB_MAX_CYC = 200
)
(
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        cal_eng_done,
   input wire logic [15:0] analog_ctrl,
   input wire logic        calib_running,
   input wire logic        local_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================
   // Helper logic
   longint run_cnt;
   logic   take;
   assign take = psel && penable && pready;
   always_ff @(posedge sys_clk or negedge nrst)
      if (!nrst)
         run_cnt <= 0;
      else
         run_cnt <= calib_running ? run_cnt + 1 : 0;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   // =====================================
   // Assertions
   irq_reset_a: assert property (
      !$past(nrst) |-> local_irq) else $error("no request after reset");
   start_run_a: assert property (
      take && pwrite && paddr == 12'h000 && pwdata[0] |-> ##[1:2] calib_running)
      else $error("calibration did not start");
   freeze_a: assert property (
      calib_running && $past(calib_running) |-> $stable(analog_ctrl))
      else $error("control changed during calibration");
   run_bound_a: assert property (
      run_cnt <= CALIB_MAX_CYC + 2) else $error("calibration too long");
   done_end_a: assert property (
      calib_running && cal_eng_done |-> ##[1:2] !calib_running)
      else $error("calibration did not finish");
   irq_hold_a: assert property (
      $fell(local_irq) |-> $past(take && pwrite && paddr == 12'h004)
      || $past(take && pwrite && paddr == 12'h004, 2))
      else $error("request dropped without a clear");
   reserved_zero_a: assert property (
      take && !pwrite && paddr == 12'h004 |-> prdata[31:8] == 24'h00_0000)
      else $error("reserved bits not zero");
   apb_answer_a: assert property (
      psel && penable && !pready |=> pready) else $error("late answer");
endmodule
bind iac_top iac_monitor #(.CALIB_MAX_CYC(CALIB_MAX_CYC)) i_iac_monitor (
   .sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .cal_eng_done(cal_eng_done),
   .analog_ctrl(analog_ctrl), .calib_running(calib_running),
   .local_irq(local_irq));

// >>> test/irq_and_calib_start_control_tb.sv
// Self-checking bench for iac_top with the host bridge model.
// Assumes the package, design and checker are compiled first.
module irq_and_calib_start_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // =====================================
   logic        sys_clk, nrst, clk_en, psel, penable, pwrite, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, cal_eng_corr, cal_corr0, rd;
   logic        pready, pslverr, cal_eng_done, cal_eng_ok, calib_running;
   logic        local_irq, host_irq;
   logic [5:0]  cnd;
   logic [15:0] ana, analog_ctrl;
   logic [1:0]  en;
   int          failures, n_tests;
   // Short calibration limit keeps the timeout run brief
   iac_top #(.CALIB_MAX_CYC(200)) i_iac_top (
      .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .init_done(cnd[0]), .sample_start(cnd[1]), .data_ready(cnd[2]),
      .burst_busy(cnd[3]), .buf_threshold(cnd[4]), .buf_over_under(cnd[5]),
      .cal_eng_done(cal_eng_done), .cal_eng_ok(cal_eng_ok),
      .cal_eng_corr(cal_eng_corr), .analog_ctrl_in(ana),
      .analog_ctrl(analog_ctrl), .calib_running(calib_running),
      .cal_corr0(cal_corr0), .local_irq(local_irq));
   iac_bridge_model i_iac_bridge_model (
      .local_irq(local_irq), .host_irq_en(en[0]), .local_in_en(en[1]),
      .host_irq(host_irq));
   // =====================================
   // Shared tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until pready is seen high at a rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd);
      @(posedge sys_clk);
      psel <= 1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1;
      // Only the watchdog ends a wait that never gets an answer
      do
      begin
         @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // =====================================
   // Scenarios
   task automatic t_reset;
      chk(32'(local_irq), 1);
      apb(0, 12'h004, 0);
      chk(rd, 32'h0000_0008);
      apb(0, 12'h000, 0);
      chk(rd, 32'h0000_0002);
      apb(1, 12'h008, 0);
      chk(32'(err), 1);
      apb(0, 12'h004, 0);
      chk(rd, 32'h0000_0008);
   endtask
   // Host line follows the request only with both enables set
   task automatic t_bridge(input logic irq_exp);
      for (int i = 0; i < 4; i++)
      begin
         en <= 2'(i);
         repeat (2) @(posedge sys_clk);
         chk(32'(local_irq), 32'(irq_exp));
         chk(32'(host_irq), 32'(irq_exp && i == 3));
      end
   endtask
   // Every event code of both groups except calib done, selected while idle first
   task automatic t_events;
      int          g[8] = '{0, 0, 0, 0, 0, 1, 1, 1};
      int          k[8] = '{0, 2, 3, 4, 5, 1, 2, 3};
      int          ix[8] = '{0, 1, 2, 3, 3, 4, 4, 5};
      logic        tv[8] = '{1, 1, 1, 1, 0, 1, 0, 1};
      logic [31:0] w;
      for (int i = 0; i < 8; i++)
      begin
         w = g[i] ? 32'(k[i]) << 4 : 32'(k[i]);
         apb(1, 12'h004, w);
         repeat (3) @(posedge sys_clk);
         chk(32'(local_irq), 0);
         cnd[ix[i]] <= ~tv[i];
         repeat (3) @(posedge sys_clk);
         chk(32'(local_irq), 0);
         cnd[ix[i]] <= tv[i];
         repeat (3) @(posedge sys_clk);
         chk(32'(local_irq), 1);
         apb(0, 12'h004, 0);
         chk(rd, w | (g[i] ? 32'h80 : 32'h8));
         apb(1, 12'h004, w);
         repeat (3) @(posedge sys_clk);
         chk(32'(local_irq), 0);
         cnd[ix[i]] <= 0;
      end
   endtask
   // Software polls calib_running until it drops rather than a fixed delay
   task automatic t_calib(input logic eng, input logic ok);
      int n;
      apb(1, 12'h004, 32'h0000_0001);
      chk(32'(analog_ctrl), 32'(ana));
      apb(1, 12'h000, 32'h0000_0001);
      repeat (2) @(posedge sys_clk);
      chk(32'(calib_running), 1);
      chk(32'(local_irq), 0);
      ana <= ~ana;
      repeat (3) @(posedge sys_clk);
      chk(32'(analog_ctrl), {16'h0000, ~ana});
      if (eng)
      begin
         cal_eng_ok <= ok;
         cal_eng_corr <= 32'hC0DE_0000 | 32'(ok);
         cal_eng_done <= 1;
         @(posedge sys_clk);
         cal_eng_done <= 0;
      end
      n = 0;
      while (calib_running !== 1'b0 && n < 400)
      begin
         @(posedge sys_clk);
         n++;
      end
      chk(32'(calib_running), 0);
      repeat (5) @(posedge sys_clk);
      chk(32'(local_irq), 1);
      chk(32'(analog_ctrl), 32'(ana));
      apb(0, 12'h000, 0);
      chk(32'(rd[0]), 0);
      chk(32'(rd[1]), 32'(eng & ok));
      if (eng)
         chk(cal_corr0, 32'hC0DE_0000 | 32'(ok));
   endtask
   // =====================================
   initial
   begin
      sys_clk = 0;
      forever #25 sys_clk = ~sys_clk;
   end
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      failures++;
      complete_run();
   end
   initial
   begin
      nrst = 0;
      clk_en = 1;
      psel = 0;
      penable = 0;
      pwrite = 0;
      paddr = 0;
      pwdata = 0;
      cnd = 0;
      ana = 16'h1234;
      en = 0;
      cal_eng_done = 0;
      cal_eng_ok = 0;
      cal_eng_corr = 0;
      failures = 0;
      n_tests = 0;
      repeat (20) @(posedge sys_clk);
      nrst <= 1;
      @(posedge sys_clk);
      t_reset();
      t_bridge(1'b1);
      // Calibrate after the reset and bridge checks, as software should after reset
      t_calib(1, 0);
      t_calib(1, 1);
      t_calib(0, 0);
      t_events();
      t_bridge(1'b0);
      complete_run();
   end
endmodule
